// [rtl/fdio_image.v]
`timescale 1ns/100ps

// Behaviour
// - io16: in sub1-2, out sub1-2, rest reserved
// - in32: four input bytes, outputs reserved
// - out32: four output bytes, inputs reserved
// - outputs latched, change only on write
// - link loss keeps last output values
// - inputs sampled together in 8-bit groups
module fdio_image #(
  parameter [1:0] VARIANT = 2'h0
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // field pins
  input wire [31:0] in_pins,
  output wire [31:0] out_pins,
  // process data from the slave controller
  input wire out_wr,
  input wire [3:0] out_sub_en,
  input wire [31:0] out_obj,
  input wire link_up,
  // process data to the slave controller
  input wire in_rd,
  output wire [31:0] in_obj,
  output wire in_valid
);

`include "fdio_map.vh"

// ==========================================================
// variant decode
function in_sub_used;
  input [1:0] var_code;
  input [1:0] sub;
  begin
    case (var_code)
      `FDIO_VAR_IO16: in_sub_used = (sub < 2'h2);
      `FDIO_VAR_IN32: in_sub_used = 1'b1;
      default: in_sub_used = 1'b0;
    endcase
  end
endfunction

function out_sub_used;
  input [1:0] var_code;
  input [1:0] sub;
  begin
    case (var_code)
      `FDIO_VAR_IO16: out_sub_used = (sub < 2'h2);
      `FDIO_VAR_OUT32: out_sub_used = 1'b1;
      default: out_sub_used = 1'b0;
    endcase
  end
endfunction

// ==========================================================
// per-variant byte masks
// the masks are constant for a build, so synthesis folds them away
function [3:0] in_used_mask;
  input [1:0] var_code;
  integer k;
  begin
    in_used_mask = 4'h0;
    for (k = 0; k < `FDIO_SUB_N; k = k + 1) begin
      in_used_mask[k] = in_sub_used(var_code, k[1:0]);
    end
  end
endfunction

function [3:0] out_used_mask;
  input [1:0] var_code;
  integer k;
  begin
    out_used_mask = 4'h0;
    for (k = 0; k < `FDIO_SUB_N; k = k + 1) begin
      out_used_mask[k] = out_sub_used(var_code, k[1:0]);
    end
  end
endfunction

// one sub-entry lane of a 32-bit object
function [7:0] lane;
  input [31:0] word;
  input [1:0] sub;
  begin
    lane = word[sub*`FDIO_SUB_W +: `FDIO_SUB_W];
  end
endfunction

// ==========================================================
// input sampling
// the pins come from another domain, so nothing reads them before the synchroniser
wire [31:0] pins_s;
wire [3:0] in_used;

assign in_used = in_used_mask(VARIANT);

fdio_sync u_sync (
  .mclk(mclk),
  .nrst(nrst),
  .async_in(in_pins),
  .sync_out(pins_s)
);

reg [31:0] in_q;
reg [31:0] in_d;
reg valid_q;
reg valid_d;
integer i;

// channel n of a group sits at bit n-1 of its byte, so a pin index maps straight through
// reserved bytes are zeroed before storage, so the held image is always legal
always @* begin
  in_d = `FDIO_IN_RST;
  for (i = 0; i < `FDIO_SUB_N; i = i + 1) begin
    if (in_used[i]) begin
      in_d[i*`FDIO_SUB_W +: `FDIO_SUB_W] = lane(pins_s, i[1:0]);
    end else begin
      in_d[i*`FDIO_SUB_W +: `FDIO_SUB_W] = `FDIO_BYTE_ZERO;
    end
  end
end

// whole image captured in one edge so a group never tears
always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    in_q <= `FDIO_IN_RST;
  end else begin
    if (in_rd) begin
      in_q <= in_d;
    end
  end
end

// valid follows the request by one edge; a held request gives a held valid
always @* begin
  valid_d = in_rd;
end

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    valid_q <= 1'b0;
  end else begin
    valid_q <= valid_d;
  end
end

assign in_obj = in_q;
assign in_valid = valid_q;

// ==========================================================
// output latch
reg [31:0] out_q;
reg [31:0] out_d;
wire [3:0] out_used;
wire [3:0] wr_bytes;
integer j;

assign out_used = out_used_mask(VARIANT);

// a byte is taken only with the strobe, its own enable and a used slot;
// anything else on the bus leaves the latch alone
assign wr_bytes = {`FDIO_SUB_N{out_wr}} & out_sub_en & out_used;

// link_up is deliberately not used here: losing the link must freeze the outputs
always @* begin
  out_d = out_q;
  for (j = 0; j < `FDIO_SUB_N; j = j + 1) begin
    if (wr_bytes[j]) begin
      out_d[j*`FDIO_SUB_W +: `FDIO_SUB_W] = lane(out_obj, j[1:0]);
    end
  end
end

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    out_q <= `FDIO_OUT_RST;
  end else begin
    out_q <= out_d;
  end
end

// ==========================================================
// link status
// the link flag is accepted only to keep the port set complete; the outputs
// keep their last written value whatever it does, so a lost master cannot
// drop a running load. the limitation is that no safe state is ever applied
// here: a user who needs one must write it before the link goes.

assign out_pins = out_q;

endmodule

// [rtl/fdio_map.vh]
`ifndef FDIO_MAP_VH
`define FDIO_MAP_VH

// ==========================================================
// variant codes (build option)
`define FDIO_VAR_IO16 2'h0
`define FDIO_VAR_IN32 2'h1
`define FDIO_VAR_OUT32 2'h2

// ==========================================================
// process image layout
`define FDIO_SUB_W 8
`define FDIO_SUB_N 4
`define FDIO_IMG_W 32
`define FDIO_CH_N 32
`define FDIO_OBJ_IN 16'h6000
`define FDIO_OBJ_OUT 16'h7000

// ==========================================================
// reset values
`define FDIO_OUT_RST 32'h0000_0000
`define FDIO_IN_RST 32'h0000_0000
`define FDIO_BYTE_ZERO 8'h00
`define FDIO_SYNC_RST 32'h0000_0000

`endif

// [rtl/fdio_sync.v]
`timescale 1ns/100ps

// ==========================================================
// two-stage synchroniser for the input pins
module fdio_sync (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // data
  input wire [31:0] async_in,
  output wire [31:0] sync_out
);

`include "fdio_map.vh"

reg [31:0] meta_q;
reg [31:0] sync_q;

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    meta_q <= `FDIO_SYNC_RST;
    sync_q <= `FDIO_SYNC_RST;
  end else begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end
end

assign sync_out = sync_q;

endmodule

// [tb/fdio_ctl_model.sv]
`timescale 1ns/100ps
module fdio_ctl (
  input wire mclk,
  output logic wr = 0, rd = 0,
  output logic [3:0] en = 0,
  output logic [31:0] obj = 0
);
  task put(input logic [3:0] e, input logic [31:0] d);
    @(posedge mclk) #1 {wr, en, obj} = {1'b1, e, d};
    // released data flips so a stale byte cannot pass
    @(posedge mclk) #1 {wr, obj} = {1'b0, ~d};
  endtask
  task get;
    @(posedge mclk) #1 rd = 1;
    @(posedge mclk) #1 rd = 0;
  endtask
endmodule

// [tb/fdio_image_chk.sv]
`timescale 1ns/100ps
module fdio_chk #(
  parameter [1:0] VARIANT = 2'h0
) (
  input wire mclk, nrst, out_wr, in_rd, in_valid, link_up,
  input wire [3:0] out_sub_en,
  input wire [31:0] out_obj, out_pins, in_obj
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_rd_valid: assert property (in_rd |=> in_valid) else $error("no valid");
  a_valid_cause: assert property (in_valid |-> $past(in_rd)) else $error("stray");
  a_out_hold: assert property (!out_wr |=> $stable(out_pins)) else $error("moved");
  a_link_hold: assert property (!link_up && !out_wr |=> $stable(out_pins)) else $error("lk");
  a_in_resv: assert property (in_valid && VARIANT == 2'h0 |-> in_obj[31:16] == 16'h0)
    else $error("in");
  a_out_resv: assert property (out_wr && VARIANT == 2'h0 |=> $stable(out_pins[31:16]))
    else $error("rs");
  a_in32_outz: assert property (VARIANT == 2'h1 |-> out_pins == 32'h0) else $error("o0");
  a_out_low: assert property (out_wr && out_sub_en[0] && VARIANT != 2'h1 |=>
    out_pins[7:0] == $past(out_obj[7:0])) else $error("byte");
  cover property (out_wr && out_sub_en[1]);
  cover property (in_valid);
  cover property ($fell(link_up));
endmodule
bind fdio_image fdio_chk #(.VARIANT(VARIANT)) u_chk (.mclk, .nrst, .out_wr, .in_rd, .in_valid, .link_up,
  .out_sub_en, .out_obj, .out_pins, .in_obj);

// [tb/fieldbus_digital_io_image_tb_top.sv]
`timescale 1ns/100ps
module fieldbus_digital_io_image_tb_top;
  logic mclk = 0, nrst = 0, link_up = 1, wr, rd, vld;
  logic [3:0] en;
  logic [31:0] obj, outp, io, e = 0, pins = 0, r = 32'h3521, q[$];
  logic [31:0] outp_i, outp_o, io_i, io_o, e32 = 0, x;
  logic vld_i, vld_o;
  int errors = 0, n_tests = 0;
  always #20 mclk = ~mclk;
  fdio_ctl u_ctl (.mclk, .wr, .rd, .en, .obj);
  fdio_image #(.VARIANT(2'h0)) u_dut (.mclk, .nrst, .in_pins(pins), .out_pins(outp),
    .out_wr(wr), .out_sub_en(en), .out_obj(obj), .link_up, .in_rd(rd), .in_obj(io),
    .in_valid(vld));
  fdio_image #(.VARIANT(2'h1)) u_dut_in32 (.mclk, .nrst, .in_pins(pins), .out_pins(outp_i),
    .out_wr(wr), .out_sub_en(en), .out_obj(obj), .link_up, .in_rd(rd), .in_obj(io_i),
    .in_valid(vld_i));
  fdio_image #(.VARIANT(2'h2)) u_dut_out32 (.mclk, .nrst, .in_pins(pins), .out_pins(outp_o),
    .out_wr(wr), .out_sub_en(en), .out_obj(obj), .link_up, .in_rd(rd), .in_obj(io_o),
    .in_valid(vld_o));
  function logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(logic [31:0] g, x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task end_sim;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge mclk) if (vld) begin
    x = q.pop_front();
    chk(io, {16'h0, x[15:0]});
    chk(io_i, x);
    chk(io_o, 32'h0);
    chk({vld_i, vld_o}, {2{vld}});
  end
  initial begin
    #100000 errors++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 nrst = 1;
    repeat (12) begin
      r = nx(r);
      pins = r;
      repeat (3) @(posedge mclk);
      q.push_back(r);
      u_ctl.get;
      r = nx(r);
      for (int s = 0; s < 4; s++) if (r[16 + s]) begin
        if (s < 2) e[8 * s +: 8] = r[8 * s +: 8];
        e32[8 * s +: 8] = r[8 * s +: 8];
      end
      u_ctl.put(r[19:16], r);
      chk(outp, e);
      chk(outp_o, e32);
      chk(outp_i, 32'h0);
      link_up = r[5];
      repeat (3) @(posedge mclk);
      #1 chk(outp, e);
      chk(outp_o, e32);
      link_up = 1;
    end
    repeat (4) @(posedge mclk);
    chk(q.size(), 0);
    end_sim;
  end
endmodule
